// ### shared/upi_pkg.sv
package upi_pkg;
    // Host address map of the pin front end
    localparam logic [6:0] UPI_LOW_SPACE_TOP = 7'h0f; // Top of the low-order address space
    localparam logic [6:0] UPI_ADDR_TX_DATA = 7'h10; // Character to send
    localparam logic [6:0] UPI_ADDR_TX_CTRL = 7'h11; // Enable, loopback, busy
    localparam logic [6:0] UPI_ADDR_A_CFG = 7'h12; // io_port_config_register: 1 = output
    localparam logic [6:0] UPI_ADDR_A_SEL_LO = 7'h13; // Function select, pins 3..0
    localparam logic [6:0] UPI_ADDR_A_SEL_HI = 7'h14; // Function select, pins 7..4
    localparam logic [6:0] UPI_ADDR_A_OUT = 7'h15; // Bank A output latch
    localparam logic [6:0] UPI_ADDR_A_PIN = 7'h16; // Bank A pin levels
    localparam logic [6:0] UPI_ADDR_A_CHG = 7'h17; // Bank A change flags, write 1 to clear
    localparam logic [6:0] UPI_ADDR_B_DIR = 7'h18; // Bank B direction: 1 = output
    localparam logic [6:0] UPI_ADDR_B_OUT = 7'h19; // Bank B output latch
    localparam logic [6:0] UPI_ADDR_B_PIN = 7'h1a; // Bank B pin levels
    localparam logic [6:0] UPI_ADDR_B_CHG = 7'h1b; // Bank B change flags, write 1 to clear
    localparam logic [6:0] UPI_ADDR_B_IEN = 7'h1c; // Bank B change interrupt enables

    // Transmit control field positions
    localparam int UPI_TXC_EN_BIT = 0;
    localparam int UPI_TXC_LOOP_BIT = 1;
    localparam int UPI_TXC_BUSY_BIT = 2;

    // Default counts
    localparam int UPI_BIT_CYCLES_DEF = 16; // Clock cycles per serial bit
    localparam int UPI_BANK_B_W_DEF = 5; // Bank B pin count
    localparam int UPI_TX_FRAME_BITS = 10; // Start, eight data, stop
    localparam logic [1:0] UPI_WARM_DONE = 2'h3; // Edges before change detection arms

    // Reset values
    localparam logic [7:0] UPI_RST_BYTE = 8'h00;
    localparam logic UPI_MARK = 1'b1; // Line level for mark
    localparam logic UPI_SPACE = 1'b0; // Line level for space

    // Bank A pin functions
    typedef enum logic [1:0] {
        UPI_FN_LATCH = 2'b00,
        UPI_FN_RX_READY = 2'b01,
        UPI_FN_TX_READY = 2'b10,
        UPI_FN_CT_READY = 2'b11
    } upi_fn_t;
endpackage

// ### verilog/upi_change_detect.sv
`timescale 1ns/1ps
module upi_change_detect import upi_pkg::*; #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Pins and clear
    input wire logic [W-1:0] pins_in,
    input wire logic [W-1:0] clear,
    // Results
    output logic [W-1:0] level,
    output logic [W-1:0] changed
);
    typedef struct packed {
        logic [W-1:0] s1; // First synchroniser stage
        logic [W-1:0] s2; // Second synchroniser stage
        logic [W-1:0] prev; // Level one cycle earlier
        logic [W-1:0] flag; // Sticky change flags
        logic [1:0] warm; // Counts edges until the pipe holds real levels
    } upi_cd_t;

    // Refuse an empty pin group
    if (W < 1) begin : g_chk_w
        $error("W out of range");
    end

    upi_cd_t st_r;
    upi_cd_t st_nxt;

    // Synchronise, compare with last level, hold flags until cleared
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pins_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.prev = st_r.s2;
        if (st_r.warm != UPI_WARM_DONE) begin
            st_nxt.warm = st_r.warm + 2'h1;
        end
        // Either edge sets, set wins over clear
        st_nxt.flag = st_r.flag & ~clear;
        if (st_r.warm == UPI_WARM_DONE) begin
            st_nxt.flag = st_nxt.flag | (st_r.s2 ^ st_r.prev);
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.s2;
    assign changed = st_r.flag;
endmodule

// ### verilog/upi_pin_front.sv
`timescale 1ns/1ps
module upi_pin_front import upi_pkg::*; #(
    parameter int BIT_CYCLES = UPI_BIT_CYCLES_DEF,
    parameter int BANK_B_W = UPI_BANK_B_W_DEF,
    parameter logic [7:0] IRQ_VECTOR = 8'h0f // Arbitrary value
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Host bus
    input wire logic bus_style_select,
    input wire logic chip_select_n,
    input wire logic read_write_select,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic iack_n,
    input wire logic [6:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n,
    output logic transfer_ack_n_out,
    output logic transfer_ack_n_oe_n,
    // Internal status sources
    input wire logic receiver_ready,
    input wire logic counter_timer_ready,
    // Serial output
    output logic txd,
    // Bank A pins
    input wire logic [7:0] bank_a_pins_in,
    output logic [7:0] bank_a_pins_out,
    output logic [7:0] bank_a_pins_oe_n,
    // Bank B pins
    input wire logic [BANK_B_W-1:0] bank_b_pins_in,
    output logic [BANK_B_W-1:0] bank_b_pins_out,
    output logic [BANK_B_W-1:0] bank_b_pins_oe_n,
    output logic bank_b_change_irq
);
    // Refuse values the logic cannot serve
    if (BIT_CYCLES < 2 || BIT_CYCLES > 65535) begin : g_chk_bit
        $error("BIT_CYCLES out of range");
    end
    if (BANK_B_W < 1 || BANK_B_W > 8) begin : g_chk_b
        $error("BANK_B_W out of range");
    end

    localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
    localparam logic [3:0] FRAME_LAST = 4'(UPI_TX_FRAME_BITS - 1);

    typedef struct packed {
        logic [7:0] dout; // Read data
        logic ack; // Acknowledge in progress
        logic in_cycle; // Current bus cycle already served
        logic tx_en; // Transmitter enable
        logic loopback; // Local loopback
        logic tx_busy; // Frame in flight
        logic [9:0] tx_shift; // Frame bits, next bit at bit 0
        logic [3:0] tx_bits; // Bits left after current
        logic [15:0] tx_cnt; // Cycles into current bit
        logic [7:0] a_cfg; // io_port_config_register
        logic [15:0] a_sel; // Two-bit function per pin
        logic [7:0] a_out; // Bank A latch
        logic low_space; // Last chip-select access hit low address space
        logic [BANK_B_W-1:0] b_dir; // Bank B direction
        logic [BANK_B_W-1:0] b_out; // Bank B latch
        logic [BANK_B_W-1:0] b_ien; // Bank B interrupt enables
    } upi_state_t;

    upi_state_t st_r;
    upi_state_t st_nxt;

    // Pin levels and change flags
    logic [7:0] a_level;
    logic [7:0] a_chg;
    logic [7:0] a_clr;
    logic [BANK_B_W-1:0] b_level;
    logic [BANK_B_W-1:0] b_chg;
    logic [BANK_B_W-1:0] b_clr;

    // Bus decode
    logic active; // Request present this cycle
    logic start; // First cycle of a request
    logic is_read;
    logic is_write;
    logic tx_ready;

    // Level of an internal signal chosen for a bank A pin
    function automatic logic upi_fn_level(input logic [1:0] sel, input logic latch,
                                          input logic rx, input logic tx, input logic ct);
        logic v;
        v = latch;
        unique case (upi_fn_t'(sel))
            UPI_FN_LATCH: v = latch;
            UPI_FN_RX_READY: v = rx;
            UPI_FN_TX_READY: v = tx;
            UPI_FN_CT_READY: v = ct;
        endcase
        return v;
    endfunction

    // Bus request decode, per bus style
    always_comb begin
        if (!bus_style_select) begin
            // Acknowledged style: chip select plus direction, or interrupt acknowledge
            active = !chip_select_n || !iack_n;
            is_read = (!chip_select_n && read_write_select) || !iack_n;
            is_write = !chip_select_n && !read_write_select && iack_n;
        end else begin
            // Strobe style: separate read and write strobes
            active = !chip_select_n && (!read_strobe_n || !write_strobe_n);
            is_read = !chip_select_n && !read_strobe_n;
            is_write = !chip_select_n && !write_strobe_n && read_strobe_n;
        end
        start = active && !st_r.in_cycle;
        tx_ready = st_r.tx_en && !st_r.tx_busy;
    end

    // Write-one-to-clear of change flags
    always_comb begin
        a_clr = '0;
        b_clr = '0;
        if (start && is_write && addr == UPI_ADDR_A_CHG) begin
            a_clr = data_in;
        end
        if (start && is_write && addr == UPI_ADDR_B_CHG) begin
            b_clr = data_in[BANK_B_W-1:0];
        end
    end

    // Next state: bus access, registers and transmitter
    always_comb begin
        st_nxt = st_r;
        // Bus cycle bookkeeping
        if (!active) begin
            st_nxt.in_cycle = 1'b0;
            st_nxt.ack = 1'b0;
        end else if (start) begin
            st_nxt.in_cycle = 1'b1;
            st_nxt.ack = !bus_style_select;
            if (!chip_select_n) begin
                st_nxt.low_space = addr <= UPI_LOW_SPACE_TOP;
            end
        end
        // Read data capture
        if (start && is_read) begin
            st_nxt.dout = UPI_RST_BYTE;
            if (!iack_n && !bus_style_select) begin
                st_nxt.dout = IRQ_VECTOR; // Interrupt acknowledge returns vector
            end else begin
                unique case (addr)
                    UPI_ADDR_TX_CTRL: begin
                        st_nxt.dout[UPI_TXC_EN_BIT] = st_r.tx_en;
                        st_nxt.dout[UPI_TXC_LOOP_BIT] = st_r.loopback;
                        st_nxt.dout[UPI_TXC_BUSY_BIT] = st_r.tx_busy;
                    end
                    UPI_ADDR_A_CFG: st_nxt.dout = st_r.a_cfg;
                    UPI_ADDR_A_SEL_LO: st_nxt.dout = st_r.a_sel[7:0];
                    UPI_ADDR_A_SEL_HI: st_nxt.dout = st_r.a_sel[15:8];
                    UPI_ADDR_A_OUT: st_nxt.dout = st_r.a_out;
                    UPI_ADDR_A_PIN: st_nxt.dout = a_level;
                    UPI_ADDR_A_CHG: st_nxt.dout = a_chg;
                    UPI_ADDR_B_DIR: st_nxt.dout[BANK_B_W-1:0] = st_r.b_dir;
                    UPI_ADDR_B_OUT: st_nxt.dout[BANK_B_W-1:0] = st_r.b_out;
                    UPI_ADDR_B_PIN: st_nxt.dout[BANK_B_W-1:0] = b_level;
                    UPI_ADDR_B_CHG: st_nxt.dout[BANK_B_W-1:0] = b_chg;
                    UPI_ADDR_B_IEN: st_nxt.dout[BANK_B_W-1:0] = st_r.b_ien;
                    default: st_nxt.dout = UPI_RST_BYTE; // Unmapped reads zero
                endcase
            end
        end
        // Register writes
        if (start && is_write) begin
            unique case (addr)
                UPI_ADDR_TX_CTRL: begin
                    st_nxt.tx_en = data_in[UPI_TXC_EN_BIT];
                    st_nxt.loopback = data_in[UPI_TXC_LOOP_BIT];
                end
                UPI_ADDR_A_CFG: st_nxt.a_cfg = data_in;
                UPI_ADDR_A_SEL_LO: st_nxt.a_sel[7:0] = data_in;
                UPI_ADDR_A_SEL_HI: st_nxt.a_sel[15:8] = data_in;
                UPI_ADDR_A_OUT: st_nxt.a_out = data_in;
                UPI_ADDR_B_DIR: st_nxt.b_dir = data_in[BANK_B_W-1:0];
                UPI_ADDR_B_OUT: st_nxt.b_out = data_in[BANK_B_W-1:0];
                UPI_ADDR_B_IEN: st_nxt.b_ien = data_in[BANK_B_W-1:0];
                default: ;
            endcase
        end
        // Transmitter: load a frame when enabled and idle
        if (start && is_write && addr == UPI_ADDR_TX_DATA && tx_ready) begin
            st_nxt.tx_busy = 1'b1;
            st_nxt.tx_shift = {UPI_MARK, data_in, UPI_SPACE};
            st_nxt.tx_bits = FRAME_LAST;
            st_nxt.tx_cnt = '0;
        end else if (st_r.tx_busy) begin
            if (st_r.tx_cnt == BIT_LAST) begin
                st_nxt.tx_cnt = '0;
                if (st_r.tx_bits == 4'h0) begin
                    st_nxt.tx_busy = 1'b0;
                end else begin
                    st_nxt.tx_shift = {UPI_MARK, st_r.tx_shift[9:1]};
                    st_nxt.tx_bits = st_r.tx_bits - 4'h1;
                end
            end else begin
                st_nxt.tx_cnt = st_r.tx_cnt + 16'h1;
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Host bus outputs
    assign data_out = st_r.dout;
    assign data_oe_n = !(is_read && st_r.in_cycle);
    assign transfer_ack_n_out = 1'b0; // Open drain, only pulls low
    assign transfer_ack_n_oe_n = !st_r.ack;

    // Serial line: mark unless a frame is running while enabled and outside loopback
    assign txd = (st_r.tx_busy && st_r.tx_en && !st_r.loopback) ?
                 st_r.tx_shift[0] : UPI_MARK;

    // Bank A pin drivers
    for (genvar i = 0; i < 8; i++) begin : g_bank_a
        logic [1:0] sel;
        logic lvl;
        assign sel = st_r.a_sel[2*i+1:2*i];
        assign lvl = upi_fn_level(sel, st_r.a_out[i], receiver_ready, tx_ready,
                                  counter_timer_ready);
        always_comb begin
            if (st_r.low_space || !st_r.a_cfg[i]) begin
                // Input only
                bank_a_pins_out[i] = 1'b0;
                bank_a_pins_oe_n[i] = 1'b1;
            end else if (sel != UPI_FN_LATCH) begin
                // Ready functions pull low only while active
                bank_a_pins_out[i] = 1'b0;
                bank_a_pins_oe_n[i] = !lvl;
            end else begin
                // Push-pull latch value
                bank_a_pins_out[i] = lvl;
                bank_a_pins_oe_n[i] = 1'b0;
            end
        end
    end

    // Bank B pins: plain I/O
    assign bank_b_pins_out = st_r.b_out & st_r.b_dir;
    assign bank_b_pins_oe_n = ~st_r.b_dir;
    assign bank_b_change_irq = |(b_chg & st_r.b_ien);

    // Change detectors, input paths always live
    upi_change_detect #(.W(8)) u_det_a (
        .ref_clk(ref_clk),
        .rst(rst),
        .pins_in(bank_a_pins_in),
        .clear(a_clr),
        .level(a_level),
        .changed(a_chg)
    );

    upi_change_detect #(.W(BANK_B_W)) u_det_b (
        .ref_clk(ref_clk),
        .rst(rst),
        .pins_in(bank_b_pins_in),
        .clear(b_clr),
        .level(b_level),
        .changed(b_chg)
    );
endmodule

// ### testbench/upi_pin_front_properties.sv
`timescale 1ns/1ps
module upi_pin_front_properties #(
    parameter int BIT_CYCLES = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Host bus
    input wire logic bus_style_select,
    input wire logic chip_select_n,
    input wire logic read_write_select,
    input wire logic iack_n,
    input wire logic [6:0] addr,
    input wire logic data_oe_n,
    input wire logic transfer_ack_n_out,
    input wire logic transfer_ack_n_oe_n,
    // Serial line and pins
    input wire logic txd,
    input wire logic [7:0] bank_a_pins_oe_n
);
    logic txd_q_r; // Line level one edge back
    logic [15:0] run_r; // Cycles the line has held its level
    // Measure each line level, saturating so idle spans never wrap
    always_ff @(posedge ref_clk) begin
        txd_q_r <= txd;
        if (rst || txd != txd_q_r) begin
            run_r <= rst ? 16'hffff : 16'h0001;
        end else if (run_r != 16'hffff) begin
            run_r <= run_r + 16'h0001;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_bus_released: assert property (chip_select_n && iack_n |-> data_oe_n)
        else $error("data bus driven while deselected");
    a_ack_strobe_off: assert property (
        bus_style_select && $past(bus_style_select) |-> transfer_ack_n_oe_n)
        else $error("acknowledge in strobe style");
    a_ack_on_request: assert property (
        !bus_style_select && ($fell(chip_select_n) || $fell(iack_n)) |=> !transfer_ack_n_oe_n)
        else $error("acknowledge missing one cycle after request");
    a_ack_release: assert property (
        !transfer_ack_n_oe_n && chip_select_n && iack_n |=> transfer_ack_n_oe_n)
        else $error("acknowledge held after request ended");
    a_ack_open_drain: assert property (transfer_ack_n_out == 1'b0)
        else $error("acknowledge drive value not low");
    a_read_drives_bus: assert property (
        !bus_style_select && $fell(chip_select_n) && read_write_select
        |=> chip_select_n || !data_oe_n)
        else $error("read data not driven");
    a_write_floats: assert property (
        !bus_style_select && !chip_select_n && !read_write_select && iack_n |-> data_oe_n)
        else $error("device drives bus during write");
    a_low_space_inputs: assert property (
        !bus_style_select && !chip_select_n && addr <= 7'h0f |=> &bank_a_pins_oe_n)
        else $error("bank A driven after low space access");
    a_txd_bit_time: assert property (txd != txd_q_r && !$past(rst) |-> run_r >= BIT_CYCLES)
        else $error("serial bit shorter than bit time");
    a_reset_idle: assert property ($fell(rst) |-> txd && (&bank_a_pins_oe_n))
        else $error("line or pins not idle after reset");
endmodule

bind upi_pin_front upi_pin_front_properties #(.BIT_CYCLES(BIT_CYCLES)) u_props (
    .ref_clk(ref_clk), .rst(rst), .bus_style_select(bus_style_select),
    .chip_select_n(chip_select_n), .read_write_select(read_write_select), .iack_n(iack_n),
    .addr(addr), .data_oe_n(data_oe_n), .transfer_ack_n_out(transfer_ack_n_out),
    .transfer_ack_n_oe_n(transfer_ack_n_oe_n), .txd(txd), .bank_a_pins_oe_n(bank_a_pins_oe_n));

// ### testbench/upi_host_model.sv
`timescale 1ns/1ps
module upi_host_model (
    // Clock
    input wire logic ref_clk,
    // Device side of the bus
    input wire logic [7:0] d_out,
    input wire logic d_oe_n,
    input wire logic ack_oe_n,
    // Host side of the bus
    output logic sty,
    output logic cs_n,
    output logic rw,
    output logic rd_n,
    output logic wr_n,
    output logic iack_n,
    output logic [6:0] addr,
    output logic [7:0] bus
);
    logic drv = 1'b0; // Host drives the data bus
    logic [7:0] wd = 8'h00; // Host write data
    logic [7:0] idle_r = 8'h5a; // Pattern of an undriven bus
    logic ack_ok = 1'b0; // Last access saw its acknowledge before the limit, or was made in strobe style
    // Shared bus level, bit 0 is D0
    assign bus = !d_oe_n ? d_out : drv ? wd : idle_r;
    // Undriven bus wanders every cycle
    always @(posedge ref_clk) idle_r <= idle_r + 8'h3b;
    // Idle bus from time zero
    initial begin
        {sty, cs_n, rw, rd_n, wr_n, iack_n} = 6'h1f;
        addr = 7'h00;
    end
    // One access: k 0 write, 1 read, 2 vector fetch
    task automatic acc(input int k, input logic [6:0] a, input logic [7:0] w,
                       output logic [7:0] r);
        int n;
        n = 0;
        @(posedge ref_clk);
        #1;
        addr = a;
        wd = w;
        drv = (k == 0);
        rw = (k == 1);
        if (k == 2) begin
            iack_n = 1'b0;
        end else begin
            cs_n = 1'b0;
            rd_n = !(sty && k == 1);
            wr_n = !(sty && k == 0);
        end
        // Hold until acknowledged, or two edges in strobe style
        do begin
            @(posedge ref_clk);
            n++;
        end while (sty ? n < 2 : (ack_oe_n !== 1'b0 && n < 20));
        ack_ok = sty || (ack_oe_n === 1'b0);
        r = bus;
        #1;
        {cs_n, rd_n, wr_n, iack_n} = 4'hf;
        drv = 1'b0;
    endtask
endmodule

// ### testbench/upi_pin_front_tb.sv
`timescale 1ns/1ps
module upi_pin_front_tb import upi_pkg::*;;
    localparam logic [7:0] VEC = 8'h5a; // Arbitrary vector value
    logic ref_clk, rst, rx_rdy, ct_rdy, sty, cs_n, rw, rd_n, wr_n, iack_n;
    logic txd, irq, d_oe_n, ack_v, ack_oe_n;
    logic [6:0] addr;
    logic [7:0] bus, d_out, rd, v, w, a_ext, a_out, a_oe_n;
    logic [4:0] b_ext, b_out, b_oe_n;
    logic [31:0] lfsr = 32'h98abe890;
    int miscompares = 0;
    int checks_done = 0;
    int i;
    // Clock, 40 ns period
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Pins: driven bits win, released bits follow the outside world
    upi_pin_front #(.BIT_CYCLES(2), .BANK_B_W(5), .IRQ_VECTOR(VEC)) u_dut (
        .ref_clk(ref_clk), .rst(rst), .bus_style_select(sty), .chip_select_n(cs_n),
        .read_write_select(rw), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .iack_n(iack_n), .addr(addr), .data_in(bus), .data_out(d_out), .data_oe_n(d_oe_n),
        .transfer_ack_n_out(ack_v), .transfer_ack_n_oe_n(ack_oe_n),
        .receiver_ready(rx_rdy), .counter_timer_ready(ct_rdy), .txd(txd),
        .bank_a_pins_in((a_out & ~a_oe_n) | (a_ext & a_oe_n)), .bank_a_pins_out(a_out),
        .bank_a_pins_oe_n(a_oe_n), .bank_b_pins_in((b_out & ~b_oe_n) | (b_ext & b_oe_n)),
        .bank_b_pins_out(b_out), .bank_b_pins_oe_n(b_oe_n), .bank_b_change_irq(irq));
    // Host processor
    upi_host_model u_host (.ref_clk(ref_clk), .d_out(d_out), .d_oe_n(d_oe_n),
        .ack_oe_n(ack_oe_n), .sty(sty), .cs_n(cs_n), .rw(rw), .rd_n(rd_n), .wr_n(wr_n),
        .iack_n(iack_n), .addr(addr), .bus(bus));
    // Random byte from the shift register
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction
    // Expected pin level from latch, direction and outside level
    function automatic logic [7:0] pin_lvl(input logic [7:0] o, dir, ext);
        return (o & dir) | (ext & ~dir);
    endfunction
    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_host.acc(0, a, d, rd);
        chk({7'h00, u_host.ack_ok}, 8'h01);
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
        u_host.acc(1, a, 8'h00, rd);
        chk({7'h00, u_host.ack_ok}, 8'h01);
        chk(rd, exp);
    endtask
    // Follow one frame from its start bit
    task automatic frame(input logic [7:0] c);
        int n, k;
        n = 0;
        while (txd !== 1'b0 && n < 40) begin
            @(posedge ref_clk);
            n++;
        end
        chk({7'h00, txd}, 8'h00);
        for (k = 0; k < 9; k++) begin
            repeat (2) @(posedge ref_clk);
            chk({7'h00, txd}, {7'h00, k < 8 ? c[k] : UPI_MARK});
        end
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial begin
        #(40 * 6000);
        miscompares++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        {rst, rx_rdy, ct_rdy, a_ext, b_ext} = {3'b100, 13'h0000};
        repeat (6) @(posedge ref_clk);
        #1 rst = 1'b0;
        chk({6'h00, txd, irq}, 8'h02);
        chk(a_oe_n, 8'hff);
        // Random directions, latches and outside levels
        repeat (6) begin
            w = rnd();
            b_ext = w[4:0];
            a_ext = rnd();
            v = rnd();
            w = rnd();
            wr(UPI_ADDR_A_CFG, v);
            wr(UPI_ADDR_A_OUT, w);
            chk(a_oe_n, ~v);
            repeat (4) @(posedge ref_clk);
            rdc(UPI_ADDR_A_PIN, pin_lvl(w, v, a_ext));
            wr(UPI_ADDR_B_DIR, v);
            wr(UPI_ADDR_B_OUT, w);
            chk({3'h0, b_oe_n}, {3'h0, ~v[4:0]});
            rdc(UPI_ADDR_B_DIR, v & 8'h1f);
            rdc(UPI_ADDR_B_PIN, pin_lvl(w, v, {3'h0, b_ext}) & 8'h1f);
        end
        // Low address space forces inputs until a high access
        wr(UPI_ADDR_A_CFG, 8'hff);
        rdc(7'h05, 8'h00);
        chk(a_oe_n, 8'hff);
        rdc(7'h1f, 8'h00);
        chk(a_oe_n, 8'h00);
        // Ready functions on pins 1..3 and 4..6 pull low only while active
        wr(UPI_ADDR_A_SEL_LO, 8'he4);
        wr(UPI_ADDR_A_SEL_HI, 8'h1b);
        wr(UPI_ADDR_TX_CTRL, 8'h01);
        for (i = 0; i < 4; i++) begin
            {ct_rdy, rx_rdy} = i[1:0];
            repeat (3) @(posedge ref_clk);
            #1;
            chk(a_oe_n, {1'b0, ~rx_rdy, 1'b0, ~ct_rdy, ~ct_rdy, 1'b0, ~rx_rdy, 1'b0});
        end
        // Frames: corner bytes then random ones
        for (i = 0; i < 4; i++) begin
            v = (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : rnd();
            fork
                wr(UPI_ADDR_TX_DATA, v);
                frame(v);
            join
            repeat (4) @(posedge ref_clk);
        end
        // Loopback then disabled: line stays at mark
        for (i = 0; i < 2; i++) begin
            wr(UPI_ADDR_TX_CTRL, i ? 8'h00 : 8'h03);
            wr(UPI_ADDR_TX_DATA, 8'h00);
            rdc(UPI_ADDR_TX_CTRL, i ? 8'h00 : 8'h07);
            repeat (24) begin
                @(posedge ref_clk);
                chk({7'h00, txd}, 8'h01);
            end
        end
        // Change flags and the gated interrupt
        wr(UPI_ADDR_A_SEL_LO, 8'h00);
        wr(UPI_ADDR_A_CFG, 8'h00);
        wr(UPI_ADDR_B_DIR, 8'h00);
        wr(UPI_ADDR_B_IEN, 8'h00);
        repeat (6) @(posedge ref_clk);
        wr(UPI_ADDR_A_CHG, 8'hff);
        wr(UPI_ADDR_B_CHG, 8'hff);
        a_ext = a_ext ^ 8'h20;
        b_ext = b_ext ^ 5'h04;
        repeat (6) @(posedge ref_clk);
        rdc(UPI_ADDR_A_CHG, 8'h20);
        rdc(UPI_ADDR_B_CHG, 8'h04);
        chk({7'h00, irq}, 8'h00);
        wr(UPI_ADDR_B_IEN, 8'h04);
        chk({7'h00, irq}, 8'h01);
        wr(UPI_ADDR_B_CHG, 8'h04);
        chk({7'h00, irq}, 8'h00);
        // Strobe-style bus, then vector fetch
        u_host.sty = 1'b1;
        wr(UPI_ADDR_B_OUT, 8'h15);
        rdc(UPI_ADDR_B_OUT, 8'h15);
        u_host.sty = 1'b0;
        u_host.acc(2, 7'h00, 8'h00, rd);
        chk(rd, VEC);
        chk({7'h00, u_host.ack_ok}, 8'h01);
        report_and_stop();
    end
endmodule
